// File: verilog/acr_params.svh
// Purpose: offsets, reset values and timing figures of the amp config bank
// Assumes: included by its bare name
// Notes: definitions only
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH
`define ACR_ADDR_CLOCK 8'h01
`define ACR_ADDR_INPUT 8'h02
`define ACR_ADDR_AUX 8'h03
`define ACR_ADDR_OUTPUT 8'h04
`define ACR_RST_CLOCK 8'h90
`define ACR_RST_INPUT 8'h40
`define ACR_RST_AUX 8'h04
`define ACR_RST_OUTPUT 8'h00
`define ACR_CLK_HZ 25000000
`define ACR_MID_32_44_HZ 38050
`define ACR_MID_44_48_HZ 46050
`define ACR_MID_48_96_HZ 72000
`define ACR_SKEW_DEPTH 16
`define ACR_NCH 3
`endif

// File: verilog/acr_pkg.sv
// Purpose: types of the amp config bank
// Assumes: nothing
// Notes: register index and decoded modes
package acr_pkg;
  typedef enum logic [2:0] {ACR_NONE, ACR_CLOCK, ACR_INPUT, ACR_AUX, ACR_OUTPUT} acr_reg_e;
  typedef logic [1:0] acr_rate_t;
endpackage : acr_pkg

// File: verilog/acr_regs.sv
// Purpose: configuration register bank of a digital audio amplifier
// Assumes: one 25 MHz clock; headphone_or_mute_input and frame_clock synchronised here
// Notes: fields drive the datapath as registered outputs
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`include "acr_params.svh"

module acr_regs import acr_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic headphone_or_mute_input,
  input wire logic frame_clock,
  input wire logic global_powerdown,
  input wire logic [`ACR_NCH-1:0] pwm_in,
  output logic [`ACR_NCH-1:0] pwm_out,
  output logic mute_request,
  output logic headphone_detect,
  output logic modulator_antiphase,
  output logic am_band_shift,
  output logic nominal_clock_valid,
  output logic input_source_select,
  output logic analog_highpass_on,
  output logic [2:0] serial_format_select,
  output logic serial_format_reserved,
  output logic aux_port_on,
  output logic delay_iface_on,
  output logic thermal_warn_on,
  output logic aux_format_select,
  output logic [1:0] aux_right_source,
  output logic [1:0] aux_left_source,
  output logic [1:0] power_stage_layout,
  output logic power_layout_reserved,
  output logic [1:0] logic_pwm_mapping,
  output logic [3:0] channel_skew
);

  function automatic acr_reg_e reg_index(input logic [7:0] a);
    case (a)
      `ACR_ADDR_CLOCK: reg_index = ACR_CLOCK;
      `ACR_ADDR_INPUT: reg_index = ACR_INPUT;
      `ACR_ADDR_AUX: reg_index = ACR_AUX;
      `ACR_ADDR_OUTPUT: reg_index = ACR_OUTPUT;
      default: reg_index = ACR_NONE;
    endcase
  endfunction : reg_index

  logic [7:0] clock_setup;
  logic [7:0] input_setup;
  logic [7:0] aux_port_setup;
  logic [7:0] output_setup;
  acr_rate_t detected_rate;
  logic [1:0] nominal_clock_select;

  assign nominal_clock_select = clock_setup[5:4];

  // Plain register writes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clock_setup <= `ACR_RST_CLOCK;
      input_setup <= `ACR_RST_INPUT;
      aux_port_setup <= `ACR_RST_AUX;
    end else if (wr) begin
      case (reg_index(addr))
        ACR_CLOCK: clock_setup <= wdata;
        // Rate and reserved bits not stored
        ACR_INPUT: input_setup <= {wdata[7:6], 3'h0, wdata[2:0]};
        ACR_AUX: aux_port_setup <= wdata;
        default: ;
      endcase
    end
  end

  // Layout and skew locked unless powered down
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      output_setup <= `ACR_RST_OUTPUT;
    end else if (wr && reg_index(addr) == ACR_OUTPUT) begin
      output_setup[5:4] <= wdata[5:4];
      if (global_powerdown) begin
        output_setup[7:6] <= wdata[7:6];
        output_setup[3:0] <= wdata[3:0];
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (reg_index(addr))
        ACR_CLOCK: rdata <= clock_setup;
        ACR_INPUT: rdata <= {input_setup[7:6], 1'b0, detected_rate, input_setup[2:0]};
        ACR_AUX: rdata <= aux_port_setup;
        ACR_OUTPUT: rdata <= output_setup;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Pin synchronisers
  logic pin_s1;
  logic pin_s2;
  logic fck_s1;
  logic fck_s2;
  logic fck_s3;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      fck_s1 <= 1'b0;
      fck_s2 <= 1'b0;
      fck_s3 <= 1'b0;
    end else begin
      pin_s1 <= headphone_or_mute_input;
      pin_s2 <= pin_s1;
      fck_s1 <= frame_clock;
      fck_s2 <= fck_s1;
      fck_s3 <= fck_s2;
    end
  end

  logic pin_active;
  assign pin_active = ~(pin_s2 ^ clock_setup[3]);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mute_request <= 1'b0;
      headphone_detect <= 1'b0;
    end else begin
      mute_request <= pin_active & ~clock_setup[2];
      headphone_detect <= pin_active & clock_setup[2];
    end
  end

  // Frame period in core clocks, thresholds at midpoints
  logic [9:0] period_cnt;
  logic frame_edge;
  assign frame_edge = fck_s2 & ~fck_s3;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      period_cnt <= 10'h000;
      detected_rate <= 2'h0;
    end else if (frame_edge) begin
      period_cnt <= 10'h001;
      // detect only with a valid select
      if (nominal_clock_select != 2'h3) begin
        if (period_cnt > 10'(`ACR_CLK_HZ / `ACR_MID_32_44_HZ)) begin
          detected_rate <= 2'h0;
        end else if (period_cnt > 10'(`ACR_CLK_HZ / `ACR_MID_44_48_HZ)) begin
          detected_rate <= 2'h1;
        end else if (period_cnt > 10'(`ACR_CLK_HZ / `ACR_MID_48_96_HZ)) begin
          detected_rate <= 2'h2;
        end else begin
          detected_rate <= 2'h3;
        end
      end
    end else if (period_cnt != 10'h3ff) begin
      period_cnt <= period_cnt + 10'h001;
    end
  end

  // Decoded fields to the datapath
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      modulator_antiphase <= 1'b0;
      am_band_shift <= 1'b0;
      nominal_clock_valid <= 1'b1;
      input_source_select <= 1'b0;
      analog_highpass_on <= 1'b1;
      serial_format_select <= 3'h0;
      serial_format_reserved <= 1'b0;
      aux_port_on <= 1'b0;
      delay_iface_on <= 1'b0;
      thermal_warn_on <= 1'b0;
      aux_format_select <= 1'b0;
      aux_right_source <= 2'h1;
      aux_left_source <= 2'h0;
      power_stage_layout <= 2'h0;
      power_layout_reserved <= 1'b0;
      logic_pwm_mapping <= 2'h0;
      channel_skew <= 4'h0;
    end else begin
      modulator_antiphase <= clock_setup[1];
      am_band_shift <= clock_setup[0];
      nominal_clock_valid <= nominal_clock_select != 2'h3;
      input_source_select <= input_setup[7];
      analog_highpass_on <= input_setup[6];
      serial_format_select <= input_setup[2:0];
      serial_format_reserved <= input_setup[2:1] == 2'h3;
      aux_port_on <= aux_port_setup[7];
      delay_iface_on <= aux_port_setup[6:5] == 2'h1;
      thermal_warn_on <= aux_port_setup[6:5] == 2'h2;
      aux_format_select <= aux_port_setup[4];
      aux_right_source <= aux_port_setup[3:2];
      aux_left_source <= aux_port_setup[1:0];
      power_stage_layout <= output_setup[7:6];
      power_layout_reserved <= output_setup[7:6] == 2'h3;
      logic_pwm_mapping <= output_setup[5:4];
      channel_skew <= output_setup[3:0];
    end
  end

  // Per-channel skew delay line
  genvar ch;
  generate
    for (ch = 0; ch < `ACR_NCH; ch++) begin : g_skew
      logic [`ACR_SKEW_DEPTH-1:0] line;
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          line <= '0;
          pwm_out[ch] <= 1'b0;
        end else begin
          line <= {line[`ACR_SKEW_DEPTH-2:0], pwm_in[ch]};
          pwm_out[ch] <= (output_setup[3:0] == 4'h0) ? pwm_in[ch] : line[output_setup[3:0] - 4'h1];
        end
      end
    end
  endgenerate

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_write(logic [7:0] a);
    wr && addr == a;
  endsequence

  sequence s_read(logic [7:0] a);
    rd && addr == a;
  endsequence

  a_clock_write: assert property (s_write(`ACR_ADDR_CLOCK) ##1 s_read(`ACR_ADDR_CLOCK) |=>
    rdata == $past(wdata, 2)) else $error("clock setup readback wrong");

  a_mute_path: assert property (!clock_setup[2] && !clock_setup[3] && !pin_s2 [*2] |=>
    mute_request && !headphone_detect) else $error("active low mute missed");

  a_hp_path: assert property (clock_setup[2] && clock_setup[3] && pin_s2 [*2] |=>
    headphone_detect && !mute_request) else $error("headphone detect missed");

  a_antiphase_flag: assert property (s_write(`ACR_ADDR_CLOCK) ##1 !wr |=>
    modulator_antiphase == $past(wdata[1], 2) && am_band_shift == $past(wdata[0], 2)) else $error("mod flags wrong");

  a_rate_read: assert property (s_read(`ACR_ADDR_INPUT) |=>
    rdata[4:3] == $past(detected_rate) && !rdata[5]) else $error("rate readback wrong");

  a_format_rsv: assert property (s_write(`ACR_ADDR_INPUT) ##1 !wr |=>
    serial_format_reserved == ($past(wdata[2:1], 2) == 2'h3)) else $error("format reserved flag wrong");

  a_delay_decode: assert property (s_write(`ACR_ADDR_AUX) ##1 !wr |=>
    delay_iface_on == ($past(wdata[6:5], 2) == 2'h1) && aux_right_source == $past(wdata[3:2], 2))
    else $error("aux decode wrong");

  a_layout_lock: assert property (s_write(`ACR_ADDR_OUTPUT) ##0 !global_powerdown |=>
    $stable(output_setup[7:6]) && $stable(output_setup[3:0])) else $error("locked field changed");

  a_skew_zero: assert property (channel_skew == 4'h0 && output_setup[3:0] == 4'h0 |=>
    pwm_out == $past(pwm_in)) else $error("zero skew not passthrough");

  a_skew_two: assert property (output_setup[3:0] == 4'h2 [*4] |->
    pwm_out == $past(pwm_in, 3)) else $error("skew of two wrong");

  a_rate_hold: assert property (nominal_clock_select == 2'h3 && frame_edge |=>
    $stable(detected_rate)) else $error("rate moved on reserved clock");

endmodule : acr_regs

// File: tb/audio_amp_config_regs_tb.sv
// Purpose: self-checking bench of the amp config register bank
// Assumes: 25 MHz core clock, bus and pins driven at the rising edge
// Notes: a byte model of the four registers predicts reads and outputs
`timescale 1ns/100ps

module audio_amp_config_regs_tb;
  logic core_clk, rstn, wr, rd, pin, frame_clock, global_powerdown, act;
  logic [7:0] addr, wdata, rdata, d;
  logic [2:0] pwm_in, pwm_out, serial_format_select;
  logic mute_request, headphone_detect, modulator_antiphase, am_band_shift, nominal_clock_valid;
  logic input_source_select, analog_highpass_on, serial_format_reserved, aux_port_on, delay_iface_on;
  logic thermal_warn_on, aux_format_select, power_layout_reserved;
  logic [1:0] aux_right_source, aux_left_source, power_stage_layout, logic_pwm_mapping, exp_rate;
  logic [3:0] channel_skew;
  logic [7:0] m [1:4];
  logic [31:0] seed;
  logic [2:0] hist [$];
  int bad_count = 0, checks = 0, cyc = 0, fper = 0;
  int pers [4] = '{781, 567, 520, 260};

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  acr_regs acr_regs_i (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .headphone_or_mute_input(pin), .frame_clock(frame_clock),
    .global_powerdown(global_powerdown), .pwm_in(pwm_in), .pwm_out(pwm_out), .mute_request(mute_request),
    .headphone_detect(headphone_detect), .modulator_antiphase(modulator_antiphase),
    .am_band_shift(am_band_shift), .nominal_clock_valid(nominal_clock_valid),
    .input_source_select(input_source_select), .analog_highpass_on(analog_highpass_on),
    .serial_format_select(serial_format_select), .serial_format_reserved(serial_format_reserved),
    .aux_port_on(aux_port_on), .delay_iface_on(delay_iface_on), .thermal_warn_on(thermal_warn_on),
    .aux_format_select(aux_format_select), .aux_right_source(aux_right_source),
    .aux_left_source(aux_left_source), .power_stage_layout(power_stage_layout),
    .power_layout_reserved(power_layout_reserved), .logic_pwm_mapping(logic_pwm_mapping),
    .channel_skew(channel_skew));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h01, 8'h03, 8'h04: return m[a[2:0]];
      8'h02: return {m[2][7:6], 1'b0, exp_rate, m[2][2:0]};
      default: return 8'h00;
    endcase
  endfunction : exp_rd

  function automatic void model_wr(input logic [7:0] a, input logic [7:0] v);
    case (a)
      8'h01, 8'h03: m[a[2:0]] = v;
      8'h02: m[2] = v & 8'hc7;
      8'h04: m[4] = global_powerdown ? v : (m[4] & 8'hcf) | (v & 8'h30);
      default: ;
    endcase
  endfunction : model_wr

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    model_wr(a, v);
  endtask : wr_reg

  // Write then read back with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b1;
    model_wr(a, v);
    @(posedge core_clk);
    rd <= 1'b0;
    #1 chk(rdata, exp_rd(a));
  endtask : wr_rd

  task automatic check_rd(input logic [7:0] a);
    logic [7:0] e;
    e = exp_rd(a);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
    chk(d, e);
    @(posedge core_clk);
    #1 chk(rdata, 8'h00);
  endtask : check_rd

  task automatic chk_out();
    logic [7:0] c, i, a, o;
    c = m[1];
    i = m[2];
    a = m[3];
    o = m[4];
    chk({modulator_antiphase, am_band_shift, nominal_clock_valid, input_source_select, analog_highpass_on,
      serial_format_select, serial_format_reserved, aux_port_on, delay_iface_on, thermal_warn_on,
      aux_format_select, aux_right_source, aux_left_source, power_stage_layout, power_layout_reserved,
      logic_pwm_mapping, channel_skew},
      {c[1], c[0], c[5:4] != 2'b11, i[7], i[6], i[2:0], i[2:1] == 2'b11, a[7], a[6:5] == 2'b01,
      a[6:5] == 2'b10, a[4], a[3:2], a[1:0], o[7:6], o[7:6] == 2'b11, o[5:4], o[3:0]});
  endtask : chk_out

  initial begin
    frame_clock = 1'b0;
    forever begin
      if (fper == 0) @(posedge core_clk);
      else begin
        repeat (fper / 2) @(posedge core_clk);
        frame_clock <= ~frame_clock;
      end
    end
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    pin = 1'b1;
    global_powerdown = 1'b0;
    pwm_in = 3'h0;
    seed = 32'h7654586a;
    exp_rate = 2'b00;
    m[1] = 8'h90;
    m[2] = 8'h40;
    m[3] = 8'h04;
    m[4] = 8'h00;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    for (int a = 0; a < 6; a++) check_rd(8'(a));
    chk_out();
    // Frame period sweep over all four rate codes
    for (int i = 0; i < 4; i++) begin
      fper = pers[i];
      exp_rate = 2'(i);
      repeat (4 * fper) @(posedge core_clk);
      check_rd(8'h02);
    end
    for (int k = 0; k < 8; k++) begin
      wr_reg(8'h01, (m[1] & 8'hf3) | {4'h0, k[1:0], 2'b00});
      @(posedge core_clk);
      pin <= k[2];
      repeat (4) @(posedge core_clk);
      #1 act = k[1] ? k[2] : !k[2];
      chk({mute_request, headphone_detect}, {act & !k[0], act & k[0]});
    end
    // Random traffic, powerdown toggled to lock and unlock the layout and skew bits of output_setup
    for (int n = 0; n < 60; n++) begin
      seed = lfsr(seed);
      @(posedge core_clk);
      global_powerdown <= seed[8];
      wr_reg({5'h00, seed[2:0]}, seed[23:16]);
      check_rd({5'h00, seed[2:0]});
      chk_out();
      wr_rd(8'h01 + 8'(seed[10:9]), seed[31:24]);
    end
    // Reserved clock select freezes rate detection
    wr_reg(8'h01, m[1] | 8'h30);
    fper = pers[0];
    repeat (4 * fper) @(posedge core_clk);
    check_rd(8'h02);
    chk_out();
    wr_reg(8'h01, (m[1] & 8'hcf) | 8'h10);
    exp_rate = 2'b00;
    repeat (4 * fper) @(posedge core_clk);
    check_rd(8'h02);
    @(posedge core_clk);
    global_powerdown <= 1'b1;
    for (int k = 0; k < 16; k = k * 2 + 2) begin
      wr_reg(8'h04, {m[4][7:4], 4'(k)});
      hist.delete();
      repeat (40) begin
        seed = lfsr(seed);
        @(posedge core_clk);
        pwm_in <= seed[2:0];
        #1 hist.push_front(pwm_in);
        if (hist.size() > k + 3) chk(pwm_out, hist[k + 1]);
      end
    end
    report_and_stop();
  end
endmodule : audio_amp_config_regs_tb
